/* logic/frs_pkg.sv */
// Shared constants for the flash resume, reset and parameter-table command block
package frs_pkg;
    // Opcodes
    localparam logic [7:0] OP_RESUME     = 8'h30;
    localparam logic [7:0] OP_NOOP       = 8'h00;
    localparam logic [7:0] OP_RESET_ARM  = 8'h66;
    localparam logic [7:0] OP_RESET      = 8'h99;
    localparam logic [7:0] OP_PARAM_READ = 8'h5a;
    // Frame bit counts, counted in serial clock edges
    localparam logic [5:0] CNT_MAX       = 6'h3f;
    localparam logic [5:0] CNT_OP_SINGLE = 6'h08;
    localparam logic [5:0] CNT_OP_QUAD   = 6'h02;
    localparam logic [5:0] CNT_ADDR_LAST = 6'h1f;
    localparam logic [5:0] CNT_DUMMY_END = 6'h27;
    // Parameter table size and fill byte
    localparam int         TBL_BYTES     = 24;
    localparam logic [7:0] TBL_FILL      = 8'hff;
    // Table bytes 00h..17h, byte 00h in the low lane; byte 10h is replaced by the maker code
    localparam logic [191:0] TBL_DATA = {
        8'hff, 8'h00, 8'h00, 8'h60, 8'h04, 8'h01, 8'h00, 8'h00,
        8'hff, 8'h00, 8'h00, 8'h30, 8'h09, 8'h01, 8'h00, 8'h00,
        8'hff, 8'h01, 8'h01, 8'h00, 8'h50, 8'h44, 8'h46, 8'h53};
    localparam int         TBL_MAKER_IDX = 16;
    // Reset recovery times and their cycle counts at the system clock
    localparam int         CLK_PERIOD_NS  = 50;
    localparam int         REC_IDLE_NS    = 1000;
    localparam int         REC_BUSY_NS    = 12000;
    localparam logic [8:0] REC_IDLE_CYC   = 9'((REC_IDLE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
    localparam logic [8:0] REC_BUSY_CYC   = 9'((REC_BUSY_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
    // Reset values
    localparam logic [23:0] ADDR_RST     = 24'h000000;
    localparam logic [2:0]  BITPOS_RST   = 3'h0;
endpackage

/* logic/frs_sync.sv */
// Two flip-flop level synchroniser
`timescale 1ns/1ps
module frs_sync (
    input  wire logic clk,     // Destination clock
    input  wire logic nrst,    // Async reset, active low
    input  wire logic d_in,    // Level from the other domain
    output logic      q_out    // Synchronised level
);
    logic meta_reg;

    // First stage feeds only the second stage
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            meta_reg <= 1'b0;
            q_out    <= 1'b0;
        end else begin
            meta_reg <= d_in;
            q_out    <= meta_reg;
        end
    end
endmodule // frs_sync

/* logic/frs_table_rom.sv */
// Parameter-table header bytes, registered read
`timescale 1ns/1ps
module frs_table_rom import frs_pkg::*; #(
    parameter logic [7:0] MAKER_CODE = 8'h5e  // Arbitrary value
) (
    input  wire logic        clk,     // Serial clock
    input  wire logic        nrst,    // Async reset, active low
    input  wire logic [23:0] addr,    // Byte address
    output logic      [7:0]  rd_data  // Registered byte
);
    logic       in_range;
    logic [4:0] idx;
    logic [7:0] byte_sel;

    // Addresses past the header area read as fill
    assign in_range = (addr < 24'(TBL_BYTES));
    assign idx      = addr[4:0];
    assign byte_sel = !in_range ? TBL_FILL :
                      (int'(idx) == TBL_MAKER_IDX) ? MAKER_CODE :
                      TBL_DATA[{idx, 3'h0} +: 8];

    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            rd_data <= TBL_FILL;
        end else begin
            rd_data <= byte_sel;
        end
    end
endmodule // frs_table_rom

/* logic/frs_cmd.sv */
// Resume, no-operation, software reset and parameter-table read command handling
// Functional notes
// RULE1 - Accepted resume clears whichever suspended flag is set and restarts the operation.
// RULE2 - Host sends resume as one opcode byte 30h alone between chip-select edges.
// RULE3 - Busy stays set after resume until the internal operation reports done.
// RULE4 - Resume needs no prior write-enable and ignores the write-enable latch.
// RULE5 - Host waits at least 1 ms after resume before another suspend.
// RULE6 - Resume is ignored while the performance-enhance read mode is active.
// RULE7 - No-operation only cancels a pending reset arm.
// RULE8 - These opcodes take 8 clocks single-line or 2 clocks quad; upper lines ignored single.
// RULE9 - Armed reset returns to standby and restores all volatile state to defaults.
// RULE10 - Reset runs only right after reset arm; any other frame disarms.
// RULE11 - Software reset during program or erase aborts that operation.
// RULE12 - Reset recovery time depends on the operation in progress; no commands meanwhile.
// RULE13 - Table read: opcode 5Ah, 3 address bytes, 1 dummy byte, then data out.
// RULE14 - Raising chip select during data out stops the output driver.
// RULE15 - Table bytes 00h..03h return 53h, 46h, 44h, 50h.
// RULE16 - Byte 04h returns 00h and byte 05h returns 01h.
// RULE17 - Byte 06h returns 01h, two headers; byte 07h returns FFh.
// RULE18 - First header: 00h, 00h, 01h, 09h, pointer 30h 00h 00h, then FFh.
// RULE19 - Second header: maker code, 00h, 01h, 04h, pointer 60h 00h 00h, then FFh.
// RULE20 - Suspend events set the matching suspended flag; resume clears it.
// RULE21 - Table data starts at the given address and advances each eight bits.
`timescale 1ns/1ps
module frs_cmd import frs_pkg::*; #(
    parameter logic [7:0] MAKER_CODE = 8'h5e  // Arbitrary value
) (
    input  wire logic       clk_sys,                // System clock, 20 MHz
    input  wire logic       nrst,                   // Async reset, active low
    input  wire logic       sclk,                   // Serial clock from the host
    input  wire logic       cs_n,                   // Chip select, active low
    input  wire logic [3:0] sio_in,                 // Data lines in; bit 0 is the single-line input
    output logic            so_out,                 // Serial data out
    output logic            so_oe_n,                // Output enable, low while driving
    input  wire logic       quad_command_mode,      // Quad command mode selected
    input  wire logic       perf_enhance_mode,      // Continuous read mode active
    input  wire logic       erase_suspend_evt,      // Pulse: erase suspended
    input  wire logic       program_suspend_evt,    // Pulse: program suspended
    input  wire logic       op_start,               // Pulse: program or erase started
    input  wire logic       op_done,                // Pulse: program or erase finished
    output logic            erase_suspended_flag,   // Erase suspended status
    output logic            program_suspended_flag, // Program suspended status
    output logic            busy_flag,              // Internal operation in progress
    output logic            resume_pulse,           // Pulse: continue suspended operation
    output logic            abort_pulse,            // Pulse: abort running operation
    output logic            soft_reset_pulse,       // Pulse: restore volatile defaults
    output logic            reset_armed,            // Reset arm pending
    output logic            recovering              // Reset recovery in progress
);
    // ---------------- Link domain (sclk) ----------------
    // The serial clock stops between frames, so
    // nothing here may wait for an edge after deselect
    // Frame state
    logic        lnk_clr;
    logic        in_frame_reg;
    logic        frame_seq_reg;
    logic [5:0]  cnt_reg;
    logic [7:0]  sh1_reg;
    logic [7:0]  sh4_reg;
    logic [23:0] addr_reg;
    logic [2:0]  bitpos_reg;
    logic        is_read_reg;
    logic        rd_active_reg;
    // Decode helpers
    logic        quad_lnk;
    logic [5:0]  cnt_cur;
    logic [5:0]  cnt_next;
    logic [7:0]  sh1_next;
    logic        addr_phase;
    logic        op_edge;
    // Table access
    logic [23:0] rom_addr;
    logic [7:0]  rom_q;

    // Mode is a system-clock level; two stages guard it
    // A mode change needs one frame of clocks to land
    frs_sync u_quad_sync (
        .clk   (sclk),
        .nrst  (nrst),
        .d_in  (quad_command_mode),
        .q_out (quad_lnk)
    );

    // Chip select or system reset clears the frame side
    assign lnk_clr    = cs_n || !nrst; // RULE14

    // Count restarts at the first edge of each frame and saturates
    // Windows: opcode 1-8, address 9-32, dummy 33-40
    assign cnt_cur    = in_frame_reg ? cnt_reg : 6'h00;
    assign cnt_next   = (cnt_cur == CNT_MAX) ? CNT_MAX : cnt_cur + 6'h01;
    assign sh1_next   = {sh1_reg[6:0], sio_in[0]};
    assign addr_phase = (cnt_cur >= CNT_OP_SINGLE) && (cnt_cur <= CNT_ADDR_LAST);
    assign op_edge    = (cnt_cur == CNT_OP_SINGLE - 6'h01);
    // Look one byte ahead on the last bit so the registered table read is in time
    assign rom_addr   = (rd_active_reg && bitpos_reg == 3'h7) ? addr_reg + 24'h1 : addr_reg; // RULE21

    // Registered table read on the rising edge leaves
    // half a clock before the falling-edge driver
    frs_table_rom #(
        .MAKER_CODE (MAKER_CODE)
    ) u_rom (
        .clk     (sclk),
        .nrst    (nrst),
        .addr    (rom_addr),
        .rd_data (rom_q)
    );

    // Frame marker; chip select high ends the frame without needing an edge
    // Low on the first edge, so the count restarts there
    always_ff @(posedge sclk or posedge lnk_clr) begin
        if (lnk_clr) begin
            in_frame_reg <= 1'b0;
        end else begin
            in_frame_reg <= 1'b1;
        end
    end

    // Shift state survives chip select so the system side can read it afterwards
    // Read there only once the serial clock is idle
    always_ff @(posedge sclk or negedge nrst) begin
        if (!nrst) begin
            frame_seq_reg <= 1'b0;
            cnt_reg       <= 6'h00;
            sh1_reg       <= 8'h00;
            sh4_reg       <= 8'h00;
        end else begin
            frame_seq_reg <= in_frame_reg ? frame_seq_reg : ~frame_seq_reg;
            cnt_reg       <= cnt_next;
            sh1_reg       <= sh1_next;
            sh4_reg       <= {sh4_reg[3:0], sio_in}; // RULE8
        end
    end

    // Table read sequencing: address, dummy, then one bit per clock
    // Quad frames never start a read; only single-line
    // frames carry the address on the input line
    always_ff @(posedge sclk or posedge lnk_clr) begin
        if (lnk_clr) begin
            is_read_reg   <= 1'b0;
            rd_active_reg <= 1'b0;
            addr_reg      <= ADDR_RST;
            bitpos_reg    <= BITPOS_RST;
        end else begin
            if (op_edge) begin
                is_read_reg <= !quad_lnk && (sh1_next == OP_PARAM_READ); // RULE13
            end
            if (addr_phase && is_read_reg) begin
                addr_reg <= {addr_reg[22:0], sio_in[0]}; // RULE13
            end
            if (is_read_reg && cnt_cur == CNT_DUMMY_END) begin
                rd_active_reg <= 1'b1;
            end
            if (rd_active_reg) begin
                bitpos_reg <= bitpos_reg + 3'h1;
                addr_reg   <= rom_addr; // RULE21
            end
        end
    end

    // Drive on the falling edge, most significant bit first; release at chip select high
    // The host samples each bit on the next rising edge
    always_ff @(negedge sclk or posedge lnk_clr) begin
        if (lnk_clr) begin
            so_out  <= 1'b0;
            so_oe_n <= 1'b1; // RULE14
        end else if (rd_active_reg) begin
            so_out  <= rom_q[3'h7 - bitpos_reg]; // RULE15 RULE16 RULE17 RULE18 RULE19
            so_oe_n <= 1'b0;
        end else begin
            so_out  <= 1'b0;
            so_oe_n <= 1'b1;
        end
    end

    // ---------------- System domain (clk_sys) ----------------
    // Commands act here once the frame has ended
    // Crossing and tracking
    logic       cs_s;
    logic       seq_s;
    logic       cs_q_reg;
    logic       seq_seen_reg;
    logic [8:0] rec_cnt_reg;
    logic [8:0] rec_cnt_next;
    // Decode
    logic       frame_end;
    logic [7:0] opcode;
    logic       len_ok;
    logic       cmd_ok;
    logic       is_resume;
    logic       is_arm;
    logic       is_reset;
    logic       do_resume;
    logic       do_reset;
    logic       suspended_any;

    // Chip select is a pin here and is synchronised
    frs_sync u_cs_sync (
        .clk   (clk_sys),
        .nrst  (nrst),
        .d_in  (cs_n),
        .q_out (cs_s)
    );

    // The toggle flags a frame that saw a clock edge
    frs_sync u_seq_sync (
        .clk   (clk_sys),
        .nrst  (nrst),
        .d_in  (frame_seq_reg),
        .q_out (seq_s)
    );

    // Opcode match, shared by the three decodes
    function automatic logic op_hit(input logic ok, input logic [7:0] op, input logic [7:0] code);
        return ok && (op == code);
    endfunction

    // Link words are read only after chip select is high, when sclk is idle and they are stable
    // Frames ending in recovery are dropped whole
    assign frame_end     = cs_s && !cs_q_reg && (seq_s != seq_seen_reg) && !recovering; // RULE12
    assign opcode        = quad_command_mode ? sh4_reg : sh1_reg; // RULE8
    assign len_ok        = (cnt_reg == (quad_command_mode ? CNT_OP_QUAD : CNT_OP_SINGLE)); // RULE8
    assign cmd_ok        = frame_end && len_ok;
    assign is_resume     = op_hit(cmd_ok, opcode, OP_RESUME); // RULE2
    assign is_arm        = op_hit(cmd_ok, opcode, OP_RESET_ARM);
    assign is_reset      = op_hit(cmd_ok, opcode, OP_RESET);
    assign suspended_any = erase_suspended_flag || program_suspended_flag;
    // No write-enable check here by design
    assign do_resume     = is_resume && suspended_any && !perf_enhance_mode; // RULE4 RULE6
    assign do_reset      = is_reset && reset_armed; // RULE10
    // Recovery length picked from what was running when reset arrived
    // Long recovery when a program or erase was cut
    assign rec_cnt_next  = do_reset ? (busy_flag ? REC_BUSY_CYC : REC_IDLE_CYC) : // RULE12
                           (rec_cnt_reg != 9'h000) ? rec_cnt_reg - 9'h001 : 9'h000;

    // Frame tracking and recovery counter
    // Reset leaves the seen marker equal, so no ghost
    always_ff @(posedge clk_sys or negedge nrst) begin
        if (!nrst) begin
            cs_q_reg     <= 1'b1;
            seq_seen_reg <= 1'b0;
            rec_cnt_reg  <= 9'h000;
            recovering   <= 1'b0;
        end else begin
            cs_q_reg     <= cs_s;
            seq_seen_reg <= (cs_s && !cs_q_reg) ? seq_s : seq_seen_reg;
            rec_cnt_reg  <= rec_cnt_next;
            recovering   <= (rec_cnt_next != 9'h000); // RULE12
        end
    end

    // Reset arm: any frame other than arm, no-operation included, drops it
    // A table read or a short frame disarms as well
    always_ff @(posedge clk_sys or negedge nrst) begin
        if (!nrst) begin
            reset_armed <= 1'b0;
        end else if (frame_end) begin
            reset_armed <= is_arm; // RULE7 RULE10
        end
    end

    // Suspend flags: a suspend event wins over a resume in the same cycle
    // Soft reset outranks both: all volatile bits return
    always_ff @(posedge clk_sys or negedge nrst) begin
        if (!nrst) begin
            erase_suspended_flag   <= 1'b0;
            program_suspended_flag <= 1'b0;
        end else if (do_reset) begin
            erase_suspended_flag   <= 1'b0; // RULE9
            program_suspended_flag <= 1'b0;
        end else begin
            erase_suspended_flag   <= erase_suspend_evt || (erase_suspended_flag && !do_resume); // RULE1 RULE20
            program_suspended_flag <= program_suspend_evt || (program_suspended_flag && !do_resume); // RULE1 RULE20
        end
    end

    // Busy: set by start or resume, cleared by done, suspend or reset
    // Host polls this to see the resumed work end
    always_ff @(posedge clk_sys or negedge nrst) begin
        if (!nrst) begin
            busy_flag <= 1'b0;
        end else if (do_reset) begin
            busy_flag <= 1'b0; // RULE9
        end else if (op_start || do_resume) begin
            busy_flag <= 1'b1; // RULE3
        end else if (op_done || erase_suspend_evt || program_suspend_evt) begin
            busy_flag <= 1'b0; // RULE3
        end
    end

    // Command pulses towards the array controller
    // One cycle each; abort only if work was running
    always_ff @(posedge clk_sys or negedge nrst) begin
        if (!nrst) begin
            resume_pulse     <= 1'b0;
            abort_pulse      <= 1'b0;
            soft_reset_pulse <= 1'b0;
        end else begin
            resume_pulse     <= do_resume; // RULE1
            abort_pulse      <= do_reset && busy_flag; // RULE11
            soft_reset_pulse <= do_reset; // RULE9
        end
    end
endmodule // frs_cmd

/* bench/frs_host.sv */
// Host controller model: frames on a 48 ns serial clock that stands still between frames
`timescale 1ns/1ps
module frs_host (
    output logic       sclk,   // Serial clock, low when idle
    output logic       cs_n,   // Chip select, active low
    output logic [3:0] sio_in  // Data lines toward the device
);
    localparam int HALF = 24;  // Half of the 48 ns period
    // Idle levels just after time zero, so the device sees the deselect edge
    initial begin
        #1;
        sclk   = 1'b0;
        cs_n   = 1'b1;
        sio_in = 4'h5;
    end
    // Header of n clocks, then rd data clocks; outside the header the lines toggle so nothing stale lingers
    task automatic xfer(input logic [39:0] hdr, input int n, input bit quad, input int rd, input logic [3:0] junk);
        cs_n = 1'b0;
        for (int i = 0; i < n + rd; i++) begin
            if (i >= n)
                sio_in = ~sio_in;
            else if (quad)
                sio_in = hdr[39 - 4 * i -: 4];
            else
                sio_in = {junk[3:1] ^ 3'(i), hdr[39 - i]};
            #HALF sclk = 1'b1;
            #HALF sclk = 1'b0;
        end
        #HALF cs_n = 1'b1;
        sio_in = ~sio_in;
        // Spacing lets each frame be seen; the bench sends suspends well within 1 ms of a resume
        #400;
    endtask
endmodule // frs_host

/* bench/frs_cmd_chk.sv */
// Assertions on the ports of the resume, reset and parameter-table command block
`timescale 1ns/1ps
module frs_cmd_chk import frs_pkg::*; (
    input wire logic clk_sys,                // System clock
    input wire logic nrst,                   // Async reset, active low
    input wire logic cs_n,                   // Chip select
    input wire logic so_oe_n,                // Output enable, low driving
    input wire logic erase_suspend_evt,      // Erase suspended event
    input wire logic program_suspend_evt,    // Program suspended event
    input wire logic op_done,                // Operation finished
    input wire logic erase_suspended_flag,   // Erase suspended status
    input wire logic program_suspended_flag, // Program suspended status
    input wire logic busy_flag,              // Busy status
    input wire logic resume_pulse,           // Resume pulse
    input wire logic abort_pulse,            // Abort pulse
    input wire logic soft_reset_pulse,       // Soft reset pulse
    input wire logic reset_armed,            // Reset arm pending
    input wire logic recovering              // Recovery running
);
    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (!nrst);
    // Recovery length; the ports do not say which kind ran, so either length is accepted
    logic [8:0] rec_cnt_reg;
    wire  [8:0] rec_cnt_next = recovering ? rec_cnt_reg + 9'h001 : 9'h000;
    always_ff @(posedge clk_sys or negedge nrst) begin
        if (!nrst) rec_cnt_reg <= 9'h000;
        else rec_cnt_reg <= rec_cnt_next;
    end
    // Flags and busy move at the same edge as each pulse
    chk_resume_flag: assert property (resume_pulse |->
        $past(erase_suspended_flag) || $past(program_suspended_flag)) else $error("resume without flag");
    chk_resume_clear: assert property (resume_pulse |->
        busy_flag && !erase_suspended_flag && !program_suspended_flag) else $error("resume state");
    chk_pulse_once: assert property (resume_pulse || soft_reset_pulse |=> !resume_pulse && !soft_reset_pulse)
        else $error("pulse longer than one cycle");
    chk_reset_armed: assert property (soft_reset_pulse |-> $past(reset_armed))
        else $error("reset without arm");
    chk_reset_clear: assert property (soft_reset_pulse |->
        !busy_flag && !erase_suspended_flag && !program_suspended_flag) else $error("reset state");
    chk_reset_abort: assert property (soft_reset_pulse || abort_pulse |->
        soft_reset_pulse && (abort_pulse == $past(busy_flag))) else $error("abort mismatch");
    chk_recover_len: assert property ($fell(recovering) |->
        rec_cnt_reg == REC_IDLE_CYC || rec_cnt_reg == REC_BUSY_CYC) else $error("recovery length");
    chk_erase_set: assert property (erase_suspend_evt |=> erase_suspended_flag)
        else $error("erase flag not set");
    chk_busy_hold: assert property ($fell(busy_flag) |-> $past(op_done) || $past(erase_suspend_evt)
        || $past(program_suspend_evt) || $past(reset_armed)) else $error("busy dropped early");
    chk_release_out: assert property (cs_n |-> so_oe_n)
        else $error("output driven while deselected");
endmodule // frs_cmd_chk

bind frs_cmd frs_cmd_chk chk_u (.clk_sys, .nrst, .cs_n, .so_oe_n, .erase_suspend_evt, .program_suspend_evt,
    .op_done, .erase_suspended_flag, .program_suspended_flag, .busy_flag, .resume_pulse, .abort_pulse,
    .soft_reset_pulse, .reset_armed, .recovering);

/* bench/test_flash_resume_reset_sfdp.sv */
// Self-checking bench for the resume, reset and parameter-table command block
`timescale 1ns/1ps
module test_flash_resume_reset_sfdp import frs_pkg::*; ;
    localparam logic [7:0] MK = 8'h3c;  // Arbitrary maker code
    logic        clk_sys, nrst, sclk, cs_n, so_out, so_oe_n, quad_command_mode, perf_enhance_mode, op_start;
    logic        erase_suspend_evt, program_suspend_evt, op_done, erase_suspended_flag, program_suspended_flag;
    logic        busy_flag, resume_pulse, abort_pulse, soft_reset_pulse, reset_armed, recovering;
    logic [3:0]  sio_in;
    logic [7:0]  q_ev[$], q_rd[$], sh;
    logic [23:0] a;
    logic [31:0] lfsr = 32'h5fc92ad3;
    int          error_cnt = 0, n_tests = 0, bit_n = 0;
    // Expected header bytes, maker code at 10h
    logic [7:0]  tbl[24] = '{8'h53, 8'h46, 8'h44, 8'h50, 8'h00, 8'h01, 8'h01, 8'hff, 8'h00, 8'h00, 8'h01, 8'h09,
                             8'h30, 8'h00, 8'h00, 8'hff, MK, 8'h00, 8'h01, 8'h04, 8'h60, 8'h00, 8'h00, 8'hff};
    wire  [7:0]  ev_w = {2'h0, resume_pulse, soft_reset_pulse, abort_pulse, erase_suspended_flag,
                         program_suspended_flag, busy_flag};
    wire  [7:0]  st_w = {3'h0, erase_suspended_flag, program_suspended_flag, busy_flag, reset_armed, recovering};
    frs_cmd #(.MAKER_CODE(MK)) dut_u (.clk_sys, .nrst, .sclk, .cs_n, .sio_in, .so_out, .so_oe_n, .quad_command_mode,
        .perf_enhance_mode, .erase_suspend_evt, .program_suspend_evt, .op_start, .op_done, .erase_suspended_flag,
        .program_suspended_flag, .busy_flag, .resume_pulse, .abort_pulse, .soft_reset_pulse, .reset_armed, .recovering);
    frs_host host_u (.sclk, .cs_n, .sio_in);
    // 20 MHz system clock
    initial begin
        clk_sys = 1'b0;
        forever #25 clk_sys = ~clk_sys;
    end
    function automatic logic [3:0] rnd();
        lfsr = {lfsr[30:0], lfsr[31] ^ lfsr[21] ^ lfsr[1] ^ lfsr[0]};
        return lfsr[3:0];
    endfunction
    function automatic logic [7:0] exp_b(input logic [23:0] ad);
        return ad < 24 ? tbl[ad[4:0]] : 8'hff;
    endfunction
    task automatic cmp(input string nm, input logic [7:0] e, input logic [7:0] g);
        n_tests++;
        if (g !== e) begin
            error_cnt++;
            $display("ERROR %s expected %h seen %h", nm, e, g);
        end
    endtask
    task automatic cmp_st(input logic [7:0] e);
        @(negedge clk_sys);
        cmp("state", e, st_w);
    endtask
    // One-cycle pulse on {erase, program suspend, start, done}
    task automatic ev(input logic [3:0] m);
        @(negedge clk_sys);
        {erase_suspend_evt, program_suspend_evt, op_start, op_done} = m;
        @(negedge clk_sys);
        {erase_suspend_evt, program_suspend_evt, op_start, op_done} = 4'h0;
    endtask
    task automatic cmd(input logic [7:0] op, input bit q);
        host_u.xfer({op, 32'h0}, q ? 2 : 8, q, 0, rnd());
    endtask
    // Host keeps quiet until recovery ends; a stuck recovery ends the run
    task automatic wait_rec();
        for (int i = 0; i < 400 && recovering !== 1'b0; i++)
            @(negedge clk_sys);
        cmp("recovery end", 8'h00, {7'h0, recovering});
        if (recovering !== 1'b0) report_and_stop();
    endtask
    task automatic report_and_stop();
        $display("Comparisons %0d, mismatches %0d", n_tests, error_cnt);
        if (error_cnt == 0 && n_tests > 0) begin
            $display("DONE - PASS");
        end else begin
            $display("DONE - FAIL");
        end
        $finish;
    endtask
    // Each pulse takes the oldest event note
    always @(negedge clk_sys)
        if (resume_pulse === 1'b1 || soft_reset_pulse === 1'b1) cmp("event", q_ev.size() > 0 ? q_ev.pop_front() : 8'hee, ev_w);
    // Table bytes assembled MSB first at the rising serial clock; a partial byte is dropped at deselect
    always @(posedge sclk) begin
        if (so_oe_n === 1'b0) begin
            sh = {sh[6:0], so_out};
            bit_n++;
        end
        if (bit_n == 8) begin
            bit_n = 0;
            cmp("table byte", q_rd.size() > 0 ? q_rd.pop_front() : 8'hee, sh);
        end
    end
    always @(posedge cs_n) bit_n = 0;
    // Main sequence
    initial begin
        #1;
        {nrst, quad_command_mode, perf_enhance_mode} = 3'h0;
        {erase_suspend_evt, program_suspend_evt, op_start, op_done} = 4'h0;
        repeat (16) @(negedge clk_sys);
        nrst = 1'b1;
        repeat (4) @(negedge clk_sys);
        ev(4'h2);
        ev(4'h8);
        cmp_st(8'h10);
        q_ev.push_back(8'h21);
        cmd(OP_RESUME, 1'b0);
        cmp_st(8'h04);
        ev(4'h1);
        cmp_st(8'h00);
        $display("Test erase resume done");
        ev(4'h2);
        ev(4'h4);
        perf_enhance_mode = 1'b1;
        cmd(OP_RESUME, 1'b0);
        cmp_st(8'h08);
        perf_enhance_mode = 1'b0;
        quad_command_mode = 1'b1;
        cmd(OP_NOOP, 1'b0);
        q_ev.push_back(8'h21);
        cmd(OP_RESUME, 1'b1);
        cmp_st(8'h04);
        cmd(OP_RESET_ARM, 1'b1);
        cmp_st(8'h06);
        quad_command_mode = 1'b0;
        cmd(OP_NOOP, 1'b0);
        ev(4'h1);
        cmp_st(8'h00);
        $display("Test program resume done");
        cmd(OP_RESUME, 1'b0);
        cmd(OP_RESET_ARM, 1'b0);
        cmp_st(8'h02);
        cmd(OP_NOOP, 1'b0);
        cmd(OP_RESET, 1'b0);
        cmp_st(8'h00);
        cmd(OP_RESET_ARM, 1'b0);
        host_u.xfer({OP_RESET, 32'h0}, 7, 1'b0, 0, rnd());
        cmp_st(8'h00);
        $display("Test reset cancel done");
        ev(4'h8);
        cmd(OP_RESET_ARM, 1'b0);
        q_ev.push_back(8'h10);
        cmd(OP_RESET, 1'b0);
        cmp_st(8'h01);
        wait_rec();
        ev(4'h2);
        cmd(OP_RESET_ARM, 1'b0);
        q_ev.push_back(8'h18);
        cmd(OP_RESET, 1'b0);
        cmp_st(8'h01);
        wait_rec();
        $display("Test software reset done");
        for (int i = 0; i < 26; i++)
            q_rd.push_back(exp_b(24'(i)));
        host_u.xfer({OP_PARAM_READ, 32'h0}, 40, 1'b0, 208, rnd());
        a = {20'h0, rnd()} + 24'h10;
        q_rd.push_back(exp_b(a));
        q_rd.push_back(exp_b(a + 24'h1));
        host_u.xfer({OP_PARAM_READ, a, 8'h0}, 40, 1'b0, 20, rnd());
        $display("Test table read done");
        cmp("leftover notes", 8'h00, 8'(q_ev.size() + q_rd.size()));
        report_and_stop();
    end
endmodule // test_flash_resume_reset_sfdp
